//--- hw/dcvh_defines.svh
`ifndef DCVH_DEFINES_SVH
`define DCVH_DEFINES_SVH

// ----------------------------------------------------------------------
// Variable numbers
// ----------------------------------------------------------------------
`define DCVH_CV_VERSION      10'h007
`define DCVH_CV_CONFIG       10'h01d
`define DCVH_CV_REFERENCE    10'h039
`define DCVH_CV_MOTOR_IF     10'h070

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DCVH_MIF_SINE_BIT    0
`define DCVH_MIF_SHORT_BIT   1
`define DCVH_MIF_ID_BIT      2
`define DCVH_CFG_STEPS_BIT   1

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define DCVH_MIF_RESET       8'h00
`define DCVH_REF_RESET       8'h00
`define DCVH_OFFSET_RESET    8'h00
`define DCVH_STEPS28_RESET   1'b1
`define DCVH_STEPS_HIGH      8'h1c
`define DCVH_STEPS_LOW       8'h0e
`define DCVH_PSEUDO_ADD      8'h64
`define DCVH_PSEUDO_ADD_NUM  10'h064

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DCVH_CLK_NS          100
`define DCVH_ACK_US          6000
`define DCVH_SHORT_HALF_NS   1000
`define DCVH_ACK_CYCLES      ((`DCVH_ACK_US * 1000) / `DCVH_CLK_NS)
`define DCVH_SHORT_HALF_CYC  ((`DCVH_SHORT_HALF_NS + `DCVH_CLK_NS - 1) / `DCVH_CLK_NS)

`endif

//--- hw/dcvh_pkg.sv
package dcvh_pkg;

    typedef enum logic [0:0] {PS_IDLE, PS_ARMED} dcvh_pseudo_t;

    typedef struct packed {
        logic         pwr_s1;
        logic         pwr_s2;
        logic         dc_s1;
        logic         dc_s2;
        dcvh_pseudo_t pseudo;
        logic [7:0]   offset;
        logic [7:0]   motor_if;
        logic [7:0]   reference;
        logic         steps28;
        logic         store_stb;
        logic [9:0]   store_num;
        logic [7:0]   store_data;
        logic [16:0]  ack_cnt;
        logic [7:0]   hf_cnt;
        logic         hf_phase;
    } dcvh_state_t;

    // Ones digit of the latched offset equals one
    function automatic logic dcvh_ones_is_one(input logic [7:0] v);
        dcvh_ones_is_one = ((v % 8'h0a) == 8'h01);
    endfunction

    // Tens digit of the latched offset equals one
    function automatic logic dcvh_tens_is_one(input logic [7:0] v);
        dcvh_tens_is_one = (((v / 8'h0a) % 8'h0a) == 8'h01);
    endfunction

endpackage

//--- hw/dcvh_pseudo_offset.sv
`timescale 1ns/100ps
`include "dcvh_defines.svh"

module dcvh_pseudo_offset
    import dcvh_pkg::*;
(
    input  wire logic       armed,     // Offset latched and pending
    input  wire logic [7:0] offset,    // Latched offset value
    input  wire logic [9:0] raw_num,   // Variable number as sent
    input  wire logic [7:0] raw_data,  // Data value as sent
    output logic      [9:0] adj_num,   // Number after offset
    output logic      [7:0] adj_data   // Data after offset
);

    logic add_num;
    logic add_data;

    always_comb
    begin
        add_data = armed && dcvh_ones_is_one(offset);
        add_num  = armed && dcvh_tens_is_one(offset);
        // Data sum past 255 and number sum past 1023 wrap; the digit scheme ignores the hundreds digit of the offset
        adj_data = add_data ? 8'(raw_data + `DCVH_PSEUDO_ADD) : raw_data;
        adj_num  = add_num ? 10'(raw_num + `DCVH_PSEUDO_ADD_NUM) : raw_num;
    end

endmodule

//--- hw/dcvh_top.sv
// Operation
// - Bit 0 of the motor interface variable switches the outputs to sine-board control.
// - Bit 1 of that variable makes programming acknowledgements high-frequency shorts.
// - Value 3 means sine board with short acknowledge, value 7 adds loco ID pulses.
// - In sine-board mode digital commands still work but analog DC driving is off.
// - In sine-board mode back-EMF regulation and its parameter variables are inert.
// - Reference zero regulates to track voltage, else a fixed reference in 0.1 V steps.
// - A factory reset selects 28 speed steps.
// - Writing the version variable latches a pseudo offset and stores nothing.
// - An offset with ones digit one adds 100 to the next written data value.
// - An offset with tens digit one adds 100 to the next written variable number.
`timescale 1ns/100ps
`include "dcvh_defines.svh"

module dcvh_top
    import dcvh_pkg::*;
#(
    parameter int ACK_CYCLES = `DCVH_ACK_CYCLES,     // Acknowledge window length
    parameter int HALF_CYC   = `DCVH_SHORT_HALF_CYC  // Half period of the short burst
)
(
    input  wire logic       CLOCK,                // 10 MHz clock
    input  wire logic       NRST,                 // Async reset, active low
    input  wire logic       CV_WR_STB,            // One-cycle variable write
    input  wire logic [9:0] CV_WR_NUM,            // Variable number of the write
    input  wire logic [7:0] CV_WR_DATA,           // Data of the write
    input  wire logic       FACTORY_RESET,        // One-cycle factory default request
    input  wire logic       POWER_LOST,           // Pin: track power absent
    input  wire logic       TRACK_IS_DC,          // Pin: analog DC supply seen
    input  wire logic       ACK_REQ,              // One-cycle acknowledge request
    output logic            CV_STORE_STB,         // One-cycle store to variable memory
    output logic      [9:0] CV_STORE_NUM,         // Number to store
    output logic      [7:0] CV_STORE_DATA,        // Data to store
    output logic            OFFSET_ARMED,         // Pseudo offset pending
    output logic            SINE_MODE,            // Outputs in sine-board layout
    output logic            ACK_SHORT_MODE,       // Acknowledge by shorts
    output logic            LOCO_ID_EN,           // Loco number ID pulses on
    output logic            DC_DRIVE_EN,          // Analog DC driving allowed
    output logic            BACK_EMF_REGULATION,  // Back-EMF regulation active
    output logic            REG_PARAMS_APPLY,     // Regulation variables in effect
    output logic            REF_FROM_TRACK,       // Reference is track voltage
    output logic      [7:0] REF_DECIVOLT,         // Fixed reference, 0.1 V units
    output logic      [7:0] SPEED_STEPS,          // Speed step count in use
    output logic            MOTOR_ACK,            // Motor-load acknowledge pulse
    output logic            SHORT_ACK             // High-frequency short burst
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam dcvh_state_t RESET_STATE = '{
        pwr_s1     : 1'b0,
        pwr_s2     : 1'b0,
        dc_s1      : 1'b0,
        dc_s2      : 1'b0,
        pseudo     : PS_IDLE,
        offset     : `DCVH_OFFSET_RESET,
        motor_if   : `DCVH_MIF_RESET,
        reference  : `DCVH_REF_RESET,
        steps28    : `DCVH_STEPS28_RESET,
        store_stb  : 1'b0,
        store_num  : 10'h000,
        store_data : 8'h00,
        ack_cnt    : 17'h00000,
        hf_cnt     : 8'h00,
        hf_phase   : 1'b0
    };

    dcvh_state_t st;
    dcvh_state_t next_st;
    logic [9:0]  adj_num;
    logic [7:0]  adj_data;
    logic        wr_version;
    logic        sine;
    logic        ack_active;

    dcvh_pseudo_offset u_offset
    (
        .armed    (st.pseudo == PS_ARMED),
        .offset   (st.offset),
        .raw_num  (CV_WR_NUM),
        .raw_data (CV_WR_DATA),
        .adj_num  (adj_num),
        .adj_data (adj_data)
    );

    assign wr_version = CV_WR_STB && (CV_WR_NUM == `DCVH_CV_VERSION);
    assign sine       = st.motor_if[`DCVH_MIF_SINE_BIT];
    assign ack_active = (st.ack_cnt != 17'h00000);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st           = st;
        next_st.pwr_s1    = POWER_LOST;
        next_st.pwr_s2    = st.pwr_s1;
        next_st.dc_s1     = TRACK_IS_DC;
        next_st.dc_s2     = st.dc_s1;
        next_st.store_stb = 1'b0;

        // Power loss drops the offset; a version write in the same cycle still arms
        if (st.pwr_s2)
        begin
            next_st.pseudo = PS_IDLE;
            next_st.offset = `DCVH_OFFSET_RESET;
        end

        unique case (st.pseudo)
            PS_IDLE:
            begin
                if (wr_version)
                begin
                    next_st.pseudo = PS_ARMED;
                    next_st.offset = CV_WR_DATA;
                end
            end
            PS_ARMED:
            begin
                // A repeated version write replaces the offset instead of using it
                if (wr_version)
                begin
                    next_st.pseudo = PS_ARMED;
                    next_st.offset = CV_WR_DATA;
                end
                else if (CV_WR_STB)
                begin
                    next_st.pseudo = PS_IDLE;
                    next_st.offset = `DCVH_OFFSET_RESET;
                end
            end
        endcase

        if (CV_WR_STB && !wr_version)
        begin
            next_st.store_stb  = 1'b1;
            next_st.store_num  = adj_num;
            next_st.store_data = adj_data;
            if (adj_num == `DCVH_CV_MOTOR_IF)
                next_st.motor_if = adj_data;
            if (adj_num == `DCVH_CV_REFERENCE)
                next_st.reference = adj_data;
            if (adj_num == `DCVH_CV_CONFIG)
                next_st.steps28 = adj_data[`DCVH_CFG_STEPS_BIT];
        end

        if (FACTORY_RESET)
        begin
            next_st.motor_if  = `DCVH_MIF_RESET;
            next_st.reference = `DCVH_REF_RESET;
            next_st.steps28   = `DCVH_STEPS28_RESET;
            next_st.pseudo    = PS_IDLE;
            next_st.offset    = `DCVH_OFFSET_RESET;
        end

        // Requests during a running window are dropped, not queued
        if (ACK_REQ && !ack_active)
            next_st.ack_cnt = 17'(ACK_CYCLES);
        else if (ack_active)
            next_st.ack_cnt = st.ack_cnt - 17'h00001;

        if (ack_active && st.motor_if[`DCVH_MIF_SHORT_BIT])
        begin
            if (st.hf_cnt == 8'(HALF_CYC - 1))
            begin
                next_st.hf_cnt   = 8'h00;
                next_st.hf_phase = !st.hf_phase;
            end
            else
                next_st.hf_cnt = st.hf_cnt + 8'h01;
        end
        else
        begin
            next_st.hf_cnt   = 8'h00;
            next_st.hf_phase = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            st <= RESET_STATE;
        else
            st <= next_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign CV_STORE_STB        = st.store_stb;
    assign CV_STORE_NUM        = st.store_num;
    assign CV_STORE_DATA       = st.store_data;
    assign OFFSET_ARMED        = (st.pseudo == PS_ARMED);
    assign SINE_MODE           = sine;
    assign ACK_SHORT_MODE      = st.motor_if[`DCVH_MIF_SHORT_BIT];
    assign LOCO_ID_EN          = (st.motor_if[2:0] == 3'h7);
    assign DC_DRIVE_EN         = st.dc_s2 && !sine;
    assign BACK_EMF_REGULATION = !sine;
    assign REG_PARAMS_APPLY    = !sine;
    assign REF_FROM_TRACK      = (st.reference == 8'h00);
    assign REF_DECIVOLT        = st.reference;
    assign SPEED_STEPS         = st.steps28 ? `DCVH_STEPS_HIGH : `DCVH_STEPS_LOW;
    // Shorts replace the load pulse because the sine board hides motor current
    assign MOTOR_ACK           = ack_active && !ACK_SHORT_MODE;
    assign SHORT_ACK           = ack_active && ACK_SHORT_MODE && st.hf_phase;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_n);

    logic plain_wr;
    assign plain_wr = CV_WR_STB && (st.pseudo == PS_IDLE) && !FACTORY_RESET;

    chk_sine_select: assert property (
        plain_wr && (CV_WR_NUM == `DCVH_CV_MOTOR_IF)
        |=> SINE_MODE == $past(CV_WR_DATA[0]))
        else $error("sine mode does not follow bit 0");

    chk_ack_select: assert property (
        plain_wr && (CV_WR_NUM == `DCVH_CV_MOTOR_IF)
        |=> ACK_SHORT_MODE == $past(CV_WR_DATA[1]) && !(MOTOR_ACK && ACK_SHORT_MODE))
        else $error("acknowledge method does not follow bit 1");

    chk_id_value: assert property (
        LOCO_ID_EN |-> SINE_MODE && ACK_SHORT_MODE)
        else $error("ID pulses enabled outside value 7");

    chk_sine_no_dc: assert property (
        SINE_MODE |-> !DC_DRIVE_EN)
        else $error("DC driving allowed in sine mode");

    chk_sine_no_back_emf_regulation: assert property (
        SINE_MODE |-> !BACK_EMF_REGULATION && !REG_PARAMS_APPLY)
        else $error("regulation active in sine mode");

    chk_ref_fixed: assert property (
        plain_wr && (CV_WR_NUM == `DCVH_CV_REFERENCE)
        |=> (REF_DECIVOLT == $past(CV_WR_DATA)) && (REF_FROM_TRACK == (REF_DECIVOLT == 8'h00)))
        else $error("reference not taken from write");

    // Only the cycle right after the request is checked; later writes may change things
    chk_factory_steps: assert property (
        FACTORY_RESET
        |=> SPEED_STEPS == `DCVH_STEPS_HIGH && !OFFSET_ARMED && !SINE_MODE && REF_FROM_TRACK)
        else $error("factory reset did not restore defaults");

    chk_version_kept: assert property (
        wr_version && !FACTORY_RESET |=> !CV_STORE_STB && OFFSET_ARMED)
        else $error("version write reached the store");

    chk_data_offset: assert property (
        CV_WR_STB && !wr_version && OFFSET_ARMED && dcvh_ones_is_one(st.offset)
        |=> CV_STORE_STB && CV_STORE_DATA == 8'($past(CV_WR_DATA) + `DCVH_PSEUDO_ADD))
        else $error("data offset not applied");

    chk_num_offset: assert property (
        CV_WR_STB && !wr_version && OFFSET_ARMED && dcvh_tens_is_one(st.offset)
        |=> CV_STORE_NUM == 10'($past(CV_WR_NUM) + `DCVH_PSEUDO_ADD_NUM))
        else $error("number offset not applied");

    chk_offset_once: assert property (
        (CV_WR_STB && !wr_version && OFFSET_ARMED) || (st.pwr_s2 && !wr_version)
        |=> !OFFSET_ARMED)
        else $error("offset survived its write or power loss");

    cov_sine_mode: cover property (
        plain_wr && CV_WR_NUM == `DCVH_CV_MOTOR_IF && CV_WR_DATA == 8'h07 ##1 LOCO_ID_EN);
    cov_pseudo_data: cover property (
        wr_version && CV_WR_DATA == 8'h01 ##[1:20] CV_STORE_STB);
    cov_pseudo_num: cover property (
        wr_version && CV_WR_DATA == 8'h0a ##[1:20] CV_STORE_STB);
    cov_short_burst: cover property (SHORT_ACK ##1 !SHORT_ACK);

endmodule

//--- sim/dcvh_station.sv
`timescale 1ns/100ps

module dcvh_station
#(
    parameter int DLY = 10  // Drive offset after the rising edge
)
(
    input  wire logic       clk,        // Bench clock
    output logic            wr_stb,     // Write strobe
    output logic      [9:0] wr_num,     // Variable number
    output logic      [7:0] wr_data,    // Write data
    output logic            power_lost  // Track power absent
);
    initial
    begin
        wr_stb     = 1'b0;
        wr_num     = 10'h3ff;
        wr_data    = 8'hff;
        power_lost = 1'b0;
    end

    // Holds one write over exactly one sampling edge, returns DLY after it
    task automatic put(input logic [9:0] n, input logic [7:0] d);
        wr_stb  = 1'b1;
        wr_num  = n;
        wr_data = d;
        @(posedge clk);
        #DLY;
    endtask

    // Idle bus shows the inverse of the last word so stale data never looks fresh;
    // one edge passes so the next write never raises the strobe in the same step
    task automatic idle();
        wr_stb  = 1'b0;
        wr_num  = ~wr_num;
        wr_data = ~wr_data;
        @(posedge clk);
        #DLY;
    endtask

    // Offset and target back to back, power held on, no speed command between;
    // strobe is left up so the caller can look at the store pulse first
    task automatic pseudo(input logic [7:0] off, input logic [9:0] n, input logic [7:0] d);
        put(10'h007, off);
        put(n, d);
    endtask

    task automatic drop_power(input int cycles);
        power_lost = 1'b1;
        repeat (cycles) @(posedge clk);
        #DLY;
        power_lost = 1'b0;
    endtask
endmodule

//--- sim/dcvh_top_test.sv
`timescale 1ns/100ps
`include "dcvh_defines.svh"

module dcvh_top_test;
    localparam int ACK_N = 50;
    localparam int HALF  = 2;
    localparam int DLY   = 10;

    logic       clock, nrst, wr_stb, power_lost, factory_reset, track_is_dc, ack_req;
    logic [9:0] wr_num, store_num;
    logic [7:0] wr_data, store_data, ref_dv, steps;
    logic       store_stb, armed, sine, short_mode, loco_id, dc_en, back_emf_regulation, reg_apply;
    logic       ref_trk, motor_ack, short_ack;
    int         n_fail;
    int         compares;
    logic [31:0] rng = 32'h4533;
    logic [7:0] corner [8] = '{8'h01, 8'h0a, 8'h0b, 8'h00, 8'h6e, 8'h15, 8'h65, 8'hff};

    dcvh_station #(.DLY(DLY)) st (.clk(clock), .wr_stb(wr_stb), .wr_num(wr_num),
        .wr_data(wr_data), .power_lost(power_lost));

    dcvh_top #(.ACK_CYCLES(ACK_N), .HALF_CYC(HALF)) DUT (
        .CLOCK(clock), .NRST(nrst), .CV_WR_STB(wr_stb), .CV_WR_NUM(wr_num),
        .CV_WR_DATA(wr_data), .FACTORY_RESET(factory_reset), .POWER_LOST(power_lost),
        .TRACK_IS_DC(track_is_dc), .ACK_REQ(ack_req), .CV_STORE_STB(store_stb),
        .CV_STORE_NUM(store_num), .CV_STORE_DATA(store_data), .OFFSET_ARMED(armed),
        .SINE_MODE(sine), .ACK_SHORT_MODE(short_mode), .LOCO_ID_EN(loco_id),
        .DC_DRIVE_EN(dc_en), .BACK_EMF_REGULATION(back_emf_regulation), .REG_PARAMS_APPLY(reg_apply),
        .REF_FROM_TRACK(ref_trk), .REF_DECIVOLT(ref_dv), .SPEED_STEPS(steps),
        .MOTOR_ACK(motor_ack), .SHORT_ACK(short_ack));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [9:0] exp_num(input logic [7:0] off, input logic [9:0] n);
        return (((off / 8'h0a) % 8'h0a) == 8'h01) ? n + 10'h064 : n;
    endfunction

    function automatic logic [7:0] exp_data(input logic [7:0] off, input logic [7:0] d);
        return ((off % 8'h0a) == 8'h01) ? d + 8'h64 : d;
    endfunction

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One write, then the store it must produce
    task automatic wr(input logic [9:0] n, input logic [7:0] d);
        st.put(n, d);
        chk_bit(store_stb, 1'b1);
        chk_val(store_num, n);
        chk_val({2'h0, store_data}, {2'h0, d});
        st.idle();
    endtask

    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        n_fail++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [7:0]  v, off, d;
        logic [9:0]  n;
        logic [31:0] r;
        nrst = 1'b0;
        factory_reset = 1'b0;
        track_is_dc = 1'b0;
        ack_req = 1'b0;
        n_fail = 0;
        compares = 0;
        repeat (16) @(posedge clock);
        #DLY;
        nrst = 1'b1;
        repeat (4) @(posedge clock);
        #DLY;
        chk_val({2'h0, steps}, 10'h01c);
        chk_bit(ref_trk, 1'b1);
        chk_bit(sine, 1'b0);
        // Every low code first, then random values; the supply kind is random in every round
        for (int i = 0; i < 16; i++)
        begin
            r = xs();
            v = (i < 8) ? 8'(i) : r[15:8];
            track_is_dc = r[0];
            wr(`DCVH_CV_MOTOR_IF, v);
            repeat (3) @(posedge clock);
            #DLY;
            chk_bit(sine, v[0]);
            chk_bit(short_mode, v[1]);
            chk_bit(loco_id, v[2:0] == 3'h7);
            chk_bit(dc_en, track_is_dc & ~v[0]);
            chk_bit(back_emf_regulation, ~v[0]);
            chk_bit(reg_apply, ~v[0]);
        end
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            v = (i == 0) ? 8'h00 : ((i == 1) ? 8'h8c : r[7:0]);
            wr(`DCVH_CV_REFERENCE, v);
            chk_bit(ref_trk, v == 8'h00);
            chk_val({2'h0, ref_dv}, {2'h0, v});
            wr(`DCVH_CV_CONFIG, r[15:8]);
            chk_val({2'h0, steps}, r[9] ? 10'h01c : 10'h00e);
        end
        // Factory defaults override a pending offset and all shadows
        wr(`DCVH_CV_CONFIG, 8'h00);
        wr(`DCVH_CV_MOTOR_IF, 8'h03);
        wr(`DCVH_CV_REFERENCE, 8'h8c);
        st.put(`DCVH_CV_VERSION, 8'h01);
        st.idle();
        chk_bit(armed, 1'b1);
        factory_reset = 1'b1;
        @(posedge clock);
        #DLY;
        factory_reset = 1'b0;
        chk_val({2'h0, steps}, 10'h01c);
        chk_bit(sine, 1'b0);
        chk_bit(ref_trk, 1'b1);
        chk_bit(armed, 1'b0);
        // Pseudo offsets: digit corners first, odd rounds back to back
        for (int i = 0; i < 40; i++)
        begin
            r = xs();
            off = (i < 8) ? corner[i] : r[7:0];
            n = 10'h008 + 10'(r[31:8] % 900);
            d = (i == 0) ? 8'hfa : r[15:8];
            if (i % 2 == 1)
                st.pseudo(off, n, d);
            else
            begin
                st.put(`DCVH_CV_VERSION, off);
                st.idle();
                chk_bit(armed, 1'b1);
                chk_bit(store_stb, 1'b0);
                st.put(n, d);
            end
            chk_bit(store_stb, 1'b1);
            chk_val(store_num, exp_num(off, n));
            chk_val({2'h0, store_data}, {2'h0, exp_data(off, d)});
            chk_bit(armed, 1'b0);
            wr(n, d);
        end
        st.put(`DCVH_CV_VERSION, 8'h0b);
        st.idle();
        st.drop_power(6);
        chk_bit(armed, 1'b0);
        repeat (4) @(posedge clock);
        #DLY;
        wr(10'h016, 8'h19);
        // Acknowledge window by load pulse, then by shorts; a request mid-window is ignored
        for (int m = 0; m < 2; m++)
        begin
            wr(`DCVH_CV_MOTOR_IF, (m == 1) ? 8'h03 : 8'h00);
            ack_req = 1'b1;
            @(posedge clock);
            #DLY;
            for (int k = 1; k <= ACK_N; k++)
            begin
                ack_req = (k == 10);
                chk_bit(motor_ack, m == 0);
                chk_bit(short_ack, (m == 1) && (((k - 1) / HALF) % 2 == 1));
                @(posedge clock);
                #DLY;
            end
            ack_req = 1'b0;
            chk_bit(motor_ack, 1'b0);
            chk_bit(short_ack, 1'b0);
        end
        end_sim();
    end
endmodule
